// file: mshl_consts.svh
// Purpose: Constants of the module serial host link
// Assumes: 50 MHz system clock
// Notes:   Counts derive from the rates below
`ifndef MSHL_CONSTS_SVH
`define MSHL_CONSTS_SVH

// ***********************************************
// Rates and framing
// ***********************************************
`define MSHL_CLK_HZ 50000000
`define MSHL_BAUD 9600
`define MSHL_OVERSAMPLE 16
`define MSHL_DATA_BITS 8
`define MSHL_FRAME_BITS 10
`define MSHL_FIFO_DEPTH 8
// Space held this many bit times is a break
`define MSHL_BREAK_BITS 20

// ***********************************************
// Terminators
// ***********************************************
`define MSHL_CHAR_CR 8'h0D
`define MSHL_CHAR_LF 8'h0A

`endif

// file: mshl_pkg.sv
// Purpose: Types of the module serial host link
// Assumes: Nothing
// Notes:   Constants live in mshl_consts.svh
package mshl_pkg;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_STOP
   } mshl_rx_state_e;

   typedef enum logic {
      TX_IDLE,
      TX_SEND
   } mshl_tx_state_e;

endpackage : mshl_pkg

// file: mshl_fifo_if.sv
// Purpose: Carrier between the link core and its receive FIFO
// Assumes: One clock
// Notes:   count reports stored words
`timescale 1ns/1ns
interface mshl_fifo_if #(
   parameter int W = 9,
   parameter int DEPTH = 8
);
   logic [W-1:0] wr_data;
   logic wr_valid;
   logic wr_ready;
   logic [W-1:0] rd_data;
   logic rd_valid;
   logic rd_ready;
   logic flush;
   logic [$clog2(DEPTH+1)-1:0] count;

   modport fifo (
      input wr_data, wr_valid, rd_ready, flush,
      output wr_ready, rd_data, rd_valid, count
   );
   modport user (
      output wr_data, wr_valid, rd_ready, flush,
      input wr_ready, rd_data, rd_valid, count
   );
endinterface : mshl_fifo_if

// file: mshl_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Synchronous active-low reset
// Notes:   Flush empties it in one cycle
`timescale 1ns/1ns
module mshl_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   mshl_fifo_if.fifo f
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);

   generate
      if (DEPTH < 2) begin : g_bad_depth
         $error("mshl_fifo: DEPTH must be at least 2");
      end
   endgenerate

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [CW-1:0] count_q;

   wire do_wr = f.wr_valid && f.wr_ready;
   wire do_rd = f.rd_valid && f.rd_ready;
   wire [AW-1:0] wr_ptr_inc = (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + AW'(1);
   wire [AW-1:0] rd_ptr_inc = (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + AW'(1);

   assign f.wr_ready = (count_q != CW'(DEPTH));
   assign f.rd_valid = (count_q != '0);
   assign f.rd_data = mem[rd_ptr_q];
   assign f.count = count_q;

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr_q] <= f.wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || f.flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (do_wr) wr_ptr_q <= wr_ptr_inc;
         if (do_rd) rd_ptr_q <= rd_ptr_inc;
         count_q <= count_q + CW'(do_wr) - CW'(do_rd);
      end
   end
endmodule : mshl_fifo

// file: mshl_host_link.sv
// Purpose: Host serial link of an instrument module: UART, flow control, status line
// Assumes: All inputs synchronous to CLK_SYS
// Notes:   Data lines use inverted polarity; rate and framing are fixed
// Function
// - Status output low while service request pending
// - RTS and CTS high means talk
// - Data line high is zero, low one
// - 9600 baud, 8 data, no parity, 1 stop
// - Rate and framing fixed, not host changeable
// - Reference clock pins unused; local clock only
// - Break restores interface power-on settings, echo off
// - Buffer until CR/LF; overflow flushes, records error (each byte is passed on as it arrives, with RX_LAST marking CR/LF)
`timescale 1ns/1ns
`include "mshl_consts.svh"
module mshl_host_link #(
   parameter int CLK_HZ = `MSHL_CLK_HZ,
   parameter int FIFO_DEPTH = `MSHL_FIFO_DEPTH
) (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic SER_TXD_IN,
   output logic SER_RXD_OUT,
   input wire logic HOST_RTS,
   output logic DEV_CTS,
   input wire logic REFERENCE_CLOCK_IN_P,
   input wire logic REFERENCE_CLOCK_IN_N,
   input wire logic SRQ_PENDING,
   output logic STATUS_N,
   output logic [7:0] RX_DATA,
   output logic RX_LAST,
   output logic RX_VALID,
   input wire logic RX_READY,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_VALID,
   output logic TX_READY,
   input wire logic ECHO_SET,
   input wire logic ECHO_CLR,
   output logic ECHO_CONSOLE_MODE,
   output logic OVERFLOW_ERR,
   input wire logic ERR_CLEAR,
   output logic BREAK_DETECTED
);
   // ***********************************************
   // Derived counts
   // ***********************************************
   localparam int TICK_DIV = CLK_HZ / (`MSHL_BAUD * `MSHL_OVERSAMPLE);
   localparam int BRK_TICKS = `MSHL_BREAK_BITS * `MSHL_OVERSAMPLE;
   localparam int DW = $clog2(TICK_DIV + 1);
   localparam int CW = $clog2(FIFO_DEPTH + 1);

   generate
      if (TICK_DIV < 2 || FIFO_DEPTH < 2) begin : g_bad_param
         $error("mshl_host_link: clock too slow or FIFO too shallow");
      end
   endgenerate

   // ***********************************************
   // Reset release
   // ***********************************************
   logic rst_s1_q;
   logic rst_n;
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // ***********************************************
   // Oversample tick divider
   // ***********************************************
   logic [DW-1:0] div_q;
   wire tick = (div_q == DW'(TICK_DIV - 1));
   always_ff @(posedge CLK_SYS) begin
      if (!rst_n || tick) div_q <= '0;
      else div_q <= div_q + DW'(1);
   end

   // ***********************************************
   // Break detection
   // ***********************************************
   wire rx_bit = ~SER_TXD_IN;
   logic [8:0] brk_cnt_q;
   wire brk = tick && !rx_bit && (brk_cnt_q == 9'(BRK_TICKS - 1));
   // Receiver stays idle until the break line returns, so no stray byte follows
   wire brk_hold = (brk_cnt_q == 9'(BRK_TICKS));
   always_ff @(posedge CLK_SYS) begin
      if (!rst_n || (tick && rx_bit)) brk_cnt_q <= '0;
      else if (tick && brk_cnt_q != 9'(BRK_TICKS)) brk_cnt_q <= brk_cnt_q + 9'(1);
   end

   // ***********************************************
   // Receiver
   // ***********************************************
   mshl_pkg::mshl_rx_state_e rx_st_q;
   logic [3:0] rx_os_q;
   logic [2:0] rx_bit_q;
   logic [7:0] rx_sh_q;
   wire rx_mid = tick && (rx_os_q == 4'h7);
   wire rx_end = tick && (rx_os_q == 4'hF);
   wire rx_done = (rx_st_q == mshl_pkg::RX_STOP) && rx_end && rx_bit;
   wire rx_term = (rx_sh_q == `MSHL_CHAR_CR) || (rx_sh_q == `MSHL_CHAR_LF);

   always_ff @(posedge CLK_SYS) begin
      if (!rst_n || brk || brk_hold) begin
         rx_st_q <= mshl_pkg::RX_IDLE;
         rx_os_q <= '0;
         rx_bit_q <= '0;
         rx_sh_q <= '0;
      end else begin
         if (tick) rx_os_q <= rx_os_q + 4'h1;
         unique case (rx_st_q)
            mshl_pkg::RX_IDLE: begin
               rx_os_q <= '0;
               if (!rx_bit) rx_st_q <= mshl_pkg::RX_START;
            end
            mshl_pkg::RX_START: begin
               if (rx_mid) begin
                  rx_os_q <= '0;
                  rx_bit_q <= '0;
                  rx_st_q <= rx_bit ? mshl_pkg::RX_IDLE : mshl_pkg::RX_DATA;
               end
            end
            mshl_pkg::RX_DATA: begin
               if (rx_end) begin
                  rx_sh_q <= {rx_bit, rx_sh_q[7:1]};
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == 3'h7) rx_st_q <= mshl_pkg::RX_STOP;
               end
            end
            mshl_pkg::RX_STOP: begin
               if (rx_end) rx_st_q <= mshl_pkg::RX_IDLE;
            end
         endcase
      end
   end

   // ***********************************************
   // Receive FIFO and output stage
   // ***********************************************
   mshl_fifo_if #(.W(9), .DEPTH(FIFO_DEPTH)) rxf ();
   mshl_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk(CLK_SYS),
      .rst_n(rst_n),
      .f(rxf)
   );

   wire ovf = rx_done && !rxf.wr_ready;
   assign rxf.wr_data = {rx_term, rx_sh_q};
   assign rxf.wr_valid = rx_done && !brk;
   assign rxf.flush = ovf || brk;
   assign rxf.rd_ready = !RX_VALID || RX_READY;
   wire rx_pop = rxf.rd_valid && rxf.rd_ready;

   always_ff @(posedge CLK_SYS) begin
      if (!rst_n || brk || ovf) begin
         RX_VALID <= 1'b0;
         RX_DATA <= '0;
         RX_LAST <= 1'b0;
      end else if (rx_pop) begin
         RX_VALID <= 1'b1;
         RX_DATA <= rxf.rd_data[7:0];
         RX_LAST <= rxf.rd_data[8];
      end else if (RX_READY) begin
         RX_VALID <= 1'b0;
      end
   end

   // ***********************************************
   // Transmit holding register and echo
   // ***********************************************
   logic hold_full_q;
   logic [7:0] hold_q;
   mshl_pkg::mshl_tx_state_e tx_st_q;
   wire user_acc = TX_VALID && TX_READY;
   wire echo_ld = ECHO_CONSOLE_MODE && rx_done && !hold_full_q && !user_acc && !ovf;
   wire tx_start = (tx_st_q == mshl_pkg::TX_IDLE) && hold_full_q && HOST_RTS;
   wire hold_full_d = (brk || ovf) ? 1'b0 :
                      (user_acc || echo_ld) ? 1'b1 :
                      tx_start ? 1'b0 : hold_full_q;

   always_ff @(posedge CLK_SYS) begin
      if (!rst_n) begin
         hold_full_q <= 1'b0;
         hold_q <= '0;
         TX_READY <= 1'b0;
      end else begin
         hold_full_q <= hold_full_d;
         TX_READY <= !hold_full_d;
         if (user_acc) hold_q <= TX_DATA;
         else if (echo_ld) hold_q <= rx_sh_q;
      end
   end

   // ***********************************************
   // Transmitter
   // ***********************************************
   logic [9:0] tx_sh_q;
   logic [3:0] tx_os_q;
   logic [3:0] tx_cnt_q;
   wire tx_bit_end = tick && (tx_os_q == 4'hF);

   always_ff @(posedge CLK_SYS) begin
      if (!rst_n || brk) begin
         tx_st_q <= mshl_pkg::TX_IDLE;
         tx_sh_q <= '1;
         tx_os_q <= '0;
         tx_cnt_q <= '0;
      end else begin
         unique case (tx_st_q)
            mshl_pkg::TX_IDLE: begin
               tx_os_q <= '0;
               tx_cnt_q <= '0;
               if (tx_start) begin
                  tx_sh_q <= {1'b1, hold_q, 1'b0};
                  tx_st_q <= mshl_pkg::TX_SEND;
               end
            end
            mshl_pkg::TX_SEND: begin
               if (tick) tx_os_q <= tx_os_q + 4'h1;
               if (tx_bit_end) begin
                  tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                  tx_cnt_q <= tx_cnt_q + 4'h1;
                  if (tx_cnt_q == 4'(`MSHL_FRAME_BITS - 1)) tx_st_q <= mshl_pkg::TX_IDLE;
               end
            end
         endcase
      end
   end

   // ***********************************************
   // Pins and status
   // ***********************************************
   always_ff @(posedge CLK_SYS) begin
      if (!rst_n) begin
         SER_RXD_OUT <= 1'b0;
         DEV_CTS <= 1'b0;
         STATUS_N <= 1'b1;
         ECHO_CONSOLE_MODE <= 1'b0;
         OVERFLOW_ERR <= 1'b0;
         BREAK_DETECTED <= 1'b0;
      end else begin
         SER_RXD_OUT <= ~tx_sh_q[0];
         DEV_CTS <= !brk && (rxf.count < CW'(FIFO_DEPTH - 1));
         STATUS_N <= !SRQ_PENDING;
         BREAK_DETECTED <= brk;
         if (brk) ECHO_CONSOLE_MODE <= 1'b0;
         else if (ECHO_SET) ECHO_CONSOLE_MODE <= 1'b1;
         else if (ECHO_CLR) ECHO_CONSOLE_MODE <= 1'b0;
         if (ovf) OVERFLOW_ERR <= 1'b1;
         else if (ERR_CLEAR) OVERFLOW_ERR <= 1'b0;
      end
   end
endmodule : mshl_host_link

// file: mshl_host_link_checker.sv
// Purpose: Port assertions for the module serial host link
// Assumes: One clock domain, CLK_SYS
// Notes:   Bound to every mshl_host_link instance
`timescale 1ns/1ns
module mshl_host_link_checker (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic SRQ_PENDING,
   input wire logic STATUS_N,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_LAST,
   input wire logic RX_VALID,
   input wire logic RX_READY,
   input wire logic ECHO_SET,
   input wire logic ECHO_CLR,
   input wire logic ECHO_CONSOLE_MODE,
   input wire logic OVERFLOW_ERR,
   input wire logic ERR_CLEAR,
   input wire logic DEV_CTS,
   input wire logic BREAK_DETECTED
);
   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   logic [1:0] up_q;
   logic live;
   // Internal reset copy ends two edges after release
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         up_q <= 2'h0;
      end else if (up_q != 2'h3) begin
         up_q <= up_q + 2'h1;
      end
   end
   assign live = (up_q == 2'h3);
   sequence rx_waiting;
      live && RX_VALID && !RX_READY;
   endsequence
   sequence rx_kept;
      RX_VALID && $stable(RX_DATA) && $stable(RX_LAST);
   endsequence
   sequence rx_cleared;
      $rose(OVERFLOW_ERR) || $rose(BREAK_DETECTED);
   endsequence
   a_status_follows: assert property (live |-> STATUS_N == !$past(SRQ_PENDING))
      else $error("status line does not follow request");
   a_break_single: assert property (BREAK_DETECTED |=> !BREAK_DETECTED)
      else $error("break pulse longer than one cycle");
   a_break_restores: assert property (live && BREAK_DETECTED |-> !ECHO_CONSOLE_MODE && !DEV_CTS)
      else $error("break left echo on or clear line up");
   a_echo_set: assert property (live && ECHO_SET |=> ECHO_CONSOLE_MODE)
      else $error("echo set ignored");
   a_echo_clear: assert property (live && ECHO_CLR && !ECHO_SET |=> !ECHO_CONSOLE_MODE)
      else $error("echo clear ignored");
   a_err_sticky: assert property (OVERFLOW_ERR && !ERR_CLEAR |=> OVERFLOW_ERR)
      else $error("overflow flag lost");
   a_rx_stands: assert property (rx_waiting |=> rx_kept or rx_cleared)
      else $error("received byte not held");
   a_last_marks: assert property (RX_VALID |-> RX_LAST == (RX_DATA == 8'h0D || RX_DATA == 8'h0A))
      else $error("terminator flag wrong");
endmodule : mshl_host_link_checker

bind mshl_host_link mshl_host_link_checker i_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
   .SRQ_PENDING(SRQ_PENDING), .STATUS_N(STATUS_N), .RX_DATA(RX_DATA), .RX_LAST(RX_LAST),
   .RX_VALID(RX_VALID), .RX_READY(RX_READY), .ECHO_SET(ECHO_SET), .ECHO_CLR(ECHO_CLR),
   .ECHO_CONSOLE_MODE(ECHO_CONSOLE_MODE), .OVERFLOW_ERR(OVERFLOW_ERR),
   .ERR_CLEAR(ERR_CLEAR), .DEV_CTS(DEV_CTS), .BREAK_DETECTED(BREAK_DETECTED));

// file: mshl_host_model.sv
// Purpose: Host side of the serial link: sender, receiver, break
// Assumes: BIT_CLKS system clocks per bit
// Notes:   obey_cts low lets a scenario overrun the device
`timescale 1ns/1ns
module mshl_host_model #(
   parameter int BIT_CLKS = 160
) (
   input wire logic clk,
   input wire logic rxd,
   input wire logic cts,
   output logic txd,
   output logic rts
);
   // ***********************************************
   // Host tasks
   // ***********************************************
   logic obey_cts = 1'b1;
   initial begin
      txd = 1'b0;
      rts = 1'b1;
   end
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b0, ~b, 1'b1};
      while (obey_cts && !cts) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         txd <= f[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
   endtask : send
   task automatic recv(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      while (!rxd && n < 4000) begin
         @(posedge clk);
         n++;
      end
      ok = rxd;
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge clk);
         b[i] = ~rxd;
      end
      repeat (BIT_CLKS) @(posedge clk);
      ok = ok && !rxd;
   endtask : recv
   task automatic brk(input int cycles);
      txd <= 1'b1;
      repeat (cycles) @(posedge clk);
      txd <= 1'b0;
   endtask : brk
endmodule : mshl_host_model

// file: test_module_serial_host_link.sv
// Purpose: Self-checking bench of the module serial host link
// Assumes: CLK_HZ lowered so one tick is 10 clocks
// Notes:   Host side is mshl_host_model
`timescale 1ns/1ns
module test_module_serial_host_link;
   // ***********************************************
   // Bench
   // ***********************************************
   localparam int BIT_CLKS = 160;
   logic clk_sys, reset_n, srq_pending, rx_ready, tx_valid, echo_set, echo_clr, err_clear;
   logic ser_txd_in, host_rts, ser_rxd_out, dev_cts, status_n, rx_last, rx_valid, tx_ready;
   logic echo_mode, overflow_err, break_detected, ok;
   logic ref_p = 1'b0;
   logic ref_n = 1'b1;
   logic [7:0] tx_data, rx_data, got;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   mshl_host_link #(.CLK_HZ(1536000)) i_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n),
      .SER_TXD_IN(ser_txd_in), .SER_RXD_OUT(ser_rxd_out), .HOST_RTS(host_rts), .DEV_CTS(dev_cts),
      .REFERENCE_CLOCK_IN_P(ref_p), .REFERENCE_CLOCK_IN_N(ref_n),
      .SRQ_PENDING(srq_pending), .STATUS_N(status_n), .RX_DATA(rx_data), .RX_LAST(rx_last),
      .RX_VALID(rx_valid), .RX_READY(rx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid),
      .TX_READY(tx_ready), .ECHO_SET(echo_set), .ECHO_CLR(echo_clr),
      .ECHO_CONSOLE_MODE(echo_mode), .OVERFLOW_ERR(overflow_err), .ERR_CLEAR(err_clear),
      .BREAK_DETECTED(break_detected));
   mshl_host_model #(.BIT_CLKS(BIT_CLKS)) i_host (.clk(clk_sys), .rxd(ser_rxd_out),
      .cts(dev_cts), .txd(ser_txd_in), .rts(host_rts));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      // Reference pair toggles to show the link ignores it
      ref_p <= ~ref_p;
      ref_n <= ~ref_n;
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (fail_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   task automatic compare(input logic [7:0] g, input logic [7:0] e, input string what);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : compare
   task automatic check_bit(input logic g, input logic e, input string what);
      compare({7'h00, g}, {7'h00, e}, what);
   endtask : check_bit
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step
   task automatic take(input logic [7:0] e, input logic last);
      int n;
      n = 0;
      while (rx_valid !== 1'b1 && n < 4000) begin
         step(1);
         n++;
      end
      compare(rx_data, e, "received byte");
      check_bit(rx_last, last, "terminator flag");
      @(posedge clk_sys);
      rx_ready <= 1'b1;
      @(posedge clk_sys);
      rx_ready <= 1'b0;
      #1;
   endtask : take
   task automatic t_status();
      @(posedge clk_sys);
      srq_pending <= 1'b1;
      step(2);
      check_bit(status_n, 1'b0, "status not asserted");
      srq_pending <= 1'b0;
      step(2);
      check_bit(status_n, 1'b1, "status not idle");
   endtask : t_status
   task automatic t_rx();
      i_host.send(8'hA5);
      i_host.send(8'h0D);
      take(8'hA5, 1'b0);
      take(8'h0D, 1'b1);
   endtask : t_rx
   task automatic t_tx();
      @(posedge clk_sys);
      i_host.rts <= 1'b0;
      tx_data <= 8'h3C;
      tx_valid <= 1'b1;
      @(posedge clk_sys);
      tx_valid <= 1'b0;
      step(300);
      check_bit(ser_rxd_out, 1'b0, "sent while host stopped");
      check_bit(tx_ready, 1'b0, "holding register not full");
      i_host.rts <= 1'b1;
      i_host.recv(got, ok);
      compare(got, 8'h3C, "transmitted byte");
      check_bit(tx_ready, 1'b1, "holding register not freed");
      check_bit(ok, 1'b1, "transmit framing");
   endtask : t_tx
   task automatic t_overflow();
      i_host.obey_cts = 1'b0;
      repeat (8) i_host.send(8'h55);
      check_bit(dev_cts, 1'b0, "clear line up when full");
      repeat (2) i_host.send(8'h55);
      step(5);
      check_bit(overflow_err, 1'b1, "overflow not flagged");
      check_bit(rx_valid, 1'b0, "buffer not discarded");
      err_clear <= 1'b1;
      step(1);
      err_clear <= 1'b0;
      step(1);
      check_bit(overflow_err, 1'b0, "overflow not cleared");
      i_host.obey_cts = 1'b1;
   endtask : t_overflow
   task automatic t_echo_break();
      int n;
      echo_set <= 1'b1;
      step(1);
      echo_set <= 1'b0;
      echo_clr <= 1'b1;
      step(1);
      echo_clr <= 1'b0;
      check_bit(echo_mode, 1'b0, "echo not cleared");
      echo_set <= 1'b1;
      step(1);
      echo_set <= 1'b0;
      fork
         i_host.send(8'h41);
         i_host.recv(got, ok);
      join
      compare(got, 8'h41, "echoed byte");
      take(8'h41, 1'b0);
      n = 0;
      fork
         i_host.brk(21 * BIT_CLKS);
         while (break_detected !== 1'b1 && n < 4000) begin
            step(1);
            n++;
         end
      join_any
      check_bit(break_detected, 1'b1, "break not seen");
      check_bit(echo_mode, 1'b0, "echo left on");
      wait fork;
      step(400);
      check_bit(rx_valid, 1'b0, "byte after break");
      check_bit(dev_cts, 1'b1, "clear line after break");
   endtask : t_echo_break
   initial begin
      reset_n = 1'b0;
      srq_pending = 1'b0;
      rx_ready = 1'b0;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      echo_set = 1'b0;
      echo_clr = 1'b0;
      err_clear = 1'b0;
      step(4);
      check_bit(status_n, 1'b1, "status in reset");
      check_bit(dev_cts, 1'b0, "clear line in reset");
      reset_n <= 1'b1;
      step(4);
      check_bit(dev_cts, 1'b1, "clear line after reset");
      check_bit(ser_rxd_out, 1'b0, "transmit idle level");
      t_status();
      t_rx();
      t_tx();
      t_overflow();
      t_echo_break();
      complete_run();
   end
endmodule : test_module_serial_host_link
